// *** raf_consts.svh ***
// Purpose: register offsets, field positions and reset values of the receive filter
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes:   definitions only
`ifndef RAF_CONSTS_SVH
`define RAF_CONSTS_SVH

`define RAF_OFS_CTRL_A        6'h00
`define RAF_OFS_CTRL_B        6'h04
`define RAF_OFS_NODE_ADDR     6'h08
`define RAF_OFS_IEEE_LO       6'h0c
`define RAF_OFS_IEEE_HI       6'h10
`define RAF_OFS_STATUS        6'h14

`define RAF_BIT_PROMISCUOUS   1
`define RAF_BIT_COORD         3
`define RAF_BIT_ACK_DISABLE   4
`define RAF_BIT_PENDING       5
`define RAF_FVN_HI            7
`define RAF_FVN_LO            6
`define RAF_BIT_SLOTTED       0
`define RAF_BIT_AUTO_ACK      1
`define RAF_BIT_RX_SAFE       7
`define RAF_ST_CRC_VALID      0
`define RAF_ST_LOCKED         1
`define RAF_ST_BUSY           2

`define RAF_RST_CTRL          8'h00
`define RAF_RST_SHORT         16'hffff
`define RAF_RST_PAN           16'hffff
`define RAF_RST_IEEE          64'h0000_0000_0000_0000
`define RAF_SHORT_NONE        16'hffff
`define RAF_SHORT_UNASSIGNED  16'hfffe
`define RAF_BCAST             16'hffff
`define RAF_CMD_DATA_REQ      8'h04

`endif

// *** raf_pkg.sv ***
// Purpose: shared types of the receive filter
// Assumes: nothing
// Notes:   constants live in raf_consts.svh
package raf_pkg;

  typedef enum logic [2:0]
  {
    RAF_FT_BEACON = 3'b000,
    RAF_FT_DATA   = 3'b001,
    RAF_FT_ACK    = 3'b010,
    RAF_FT_CMD    = 3'b011
  } raf_ftype_t;

  typedef enum logic [1:0]
  {
    RAF_IDLE     = 2'b00,
    RAF_RECV     = 2'b01,
    RAF_ACK_WAIT = 2'b10
  } raf_rx_state_t;

endpackage : raf_pkg

// *** raf_mhr_if.sv ***
// Purpose: carries the received byte stream and the parsed header fields
// Assumes: one byte per valid cycle, start pulse before the first byte
// Notes:   fields are stable from the first payload byte until the next start
`timescale 1ns/100ps
`default_nettype none
interface raf_mhr_if;
  logic        start;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic [15:0] fcf;
  logic [7:0]  seq;
  logic [15:0] dst_pan;
  logic [63:0] dst_addr;
  logic [7:0]  cmd_id;

  modport parser (input start, input byte_valid, input byte_data,
                  output fcf, output seq, output dst_pan, output dst_addr, output cmd_id);
  modport filter (output start, output byte_valid, output byte_data,
                  input fcf, input seq, input dst_pan, input dst_addr, input cmd_id);
endinterface : raf_mhr_if
`default_nettype wire

// *** raf_mhr_parse.sv ***
// Purpose: extracts frame control, sequence, destination and command id from the MAC header
// Assumes: little-endian field order of the MAC header
// Notes:   address fields not present in a frame keep zero; cmd holds the first payload byte of any frame type
`timescale 1ns/100ps
`default_nettype none
module raf_mhr_parse
(
  input  wire logic sys_clk,
  input  wire logic srst,
  raf_mhr_if.parser mhr
);

  typedef struct packed
  {
    logic [6:0]  idx;
    logic [15:0] fcf;
    logic [7:0]  seq;
    logic [15:0] pan;
    logic [63:0] addr;
    logic [7:0]  cmd;
  } raf_parse_state_t;

  raf_parse_state_t s_q;
  raf_parse_state_t s_d;

  // header length in bytes up to the first payload byte
  function automatic logic [6:0] raf_hdr_len(input logic [15:0] fcf);
    logic [6:0] n;
    n = 7'd3;
    if (fcf[11:10] != 2'b00) n = n + 7'd2;
    if (fcf[11:10] == 2'b10) n = n + 7'd2;
    if (fcf[11:10] == 2'b11) n = n + 7'd8;
    if (fcf[15:14] != 2'b00 && !(fcf[6] && fcf[11:10] != 2'b00)) n = n + 7'd2;
    if (fcf[15:14] == 2'b10) n = n + 7'd2;
    if (fcf[15:14] == 2'b11) n = n + 7'd8;
    return n;
  endfunction : raf_hdr_len

  always_comb
  begin
    logic [6:0] ai;
    ai  = s_q.idx - 7'd5;
    s_d = s_q;
    if (mhr.start)
    begin
      s_d = '0;
    end
    else if (mhr.byte_valid)
    begin
      if (s_q.idx != 7'h7f) s_d.idx = s_q.idx + 7'd1;
      case (s_q.idx)
        7'd0: s_d.fcf[7:0]  = mhr.byte_data;
        7'd1: s_d.fcf[15:8] = mhr.byte_data;
        7'd2: s_d.seq       = mhr.byte_data;
        7'd3: if (s_q.fcf[11:10] != 2'b00) s_d.pan[7:0]  = mhr.byte_data;
        7'd4: if (s_q.fcf[11:10] != 2'b00) s_d.pan[15:8] = mhr.byte_data;
        default: ;
      endcase
      if (s_q.idx >= 7'd5 && ((s_q.fcf[11:10] == 2'b10 && ai < 7'd2) ||
                              (s_q.fcf[11:10] == 2'b11 && ai < 7'd8)))
        s_d.addr[{ai[2:0], 3'b000} +: 8] = mhr.byte_data;
      if (s_q.idx == raf_hdr_len(s_q.fcf) && s_q.idx > 7'd2)
        s_d.cmd = mhr.byte_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst) s_q <= '0;
    else      s_q <= s_d;
  end

  assign mhr.fcf      = s_q.fcf;
  assign mhr.seq      = s_q.seq;
  assign mhr.dst_pan  = s_q.pan;
  assign mhr.dst_addr = s_q.addr;
  assign mhr.cmd_id   = s_q.cmd;

endmodule : raf_mhr_parse
`default_nettype wire

// *** raf_rx_filter.sv ***
// Purpose: receive frame filter and automatic acknowledge decision with Avalon-MM registers
// Assumes: phy delivers header-valid pulse, bytes, then done pulse with fcs result
// Notes:   one register answer per request, waitrequest drops one cycle after it
//
// Added by the designer: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "raf_consts.svh"
// What this block does
// - version field selects which versions get acknowledged
// - slotted bit makes ack wait for slot trigger
// - safe bit locks buffer after received frame
// - coordinator bit accepts data and command frames without destination
// - pending flag gives ack pending subfield value
// - no short address: only broadcast or extended
// - promiscuous bit puts filter in promiscuous mode
// - ack disable bit suppresses the ack of every frame that ends while it is set
// - promiscuous applies second level checks only
// - promiscuous raises receive end despite bad fcs
// - promiscuous without disable still acks matching frames
// - address match interrupt in every receive mode
// - valid header raises receive start interrupt
// - fcs valid updated with receive end
// - ack carries received sequence number
// - pending subfield only for data requests
module raf_rx_filter
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        phy_hdr_valid,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_fcs_ok,
  input  wire logic        ack_slot_trigger,
  output logic             rx_start_irq,
  output logic             rx_end_irq,
  output logic             address_match_irq,
  output logic             ack_tx_start,
  output logic      [7:0]  ack_seq,
  output logic             ack_frame_pending
);

  typedef struct packed
  {
    raf_pkg::raf_rx_state_t st;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] short_addr;
    logic [15:0] network_id;
    logic [63:0] ieee;
    logic        crc_valid;
    logic        locked;
    logic        wait_n;
    logic [31:0] rdata;
    logic        start_p;
    logic        end_p;
    logic        ami_p;
    logic        ack_p;
    logic [7:0]  ack_seq;
    logic        ack_pend;
  } raf_state_t;

  raf_state_t s_q;
  raf_state_t s_d;
  raf_mhr_if  mhr ();

  raf_mhr_parse u_parse
  (
    .sys_clk (sys_clk),
    .srst    (srst),
    .mhr     (mhr)
  );

  // frame version accepted for acknowledgement under the given selection
  function automatic logic raf_ver_ok(input logic [1:0] sel, input logic [1:0] ver);
    return (sel == 2'b11) || (ver <= sel);
  endfunction : raf_ver_ok

  function automatic logic raf_is_short(input logic [15:0] a);
    return (a != `RAF_SHORT_NONE) && (a != `RAF_SHORT_UNASSIGNED);
  endfunction : raf_is_short

  logic        promisc;
  logic        coord;
  logic        ack_dis;
  logic        pend_flag;
  logic [1:0]  fvn_sel;
  logic        slotted;
  logic        auto_ack;
  logic        rx_safe;
  logic [2:0]  ftype;
  logic [1:0]  dmode;
  logic        pan_ok;
  logic        lvl2_ok;
  logic        addr_ok;
  logic        ack_want;
  logic        bus_req;
  logic        bus_take;

  assign promisc   = s_q.ctrl_a[`RAF_BIT_PROMISCUOUS];
  assign coord     = s_q.ctrl_a[`RAF_BIT_COORD];
  assign ack_dis   = s_q.ctrl_a[`RAF_BIT_ACK_DISABLE];
  assign pend_flag = s_q.ctrl_a[`RAF_BIT_PENDING];
  assign fvn_sel   = s_q.ctrl_a[`RAF_FVN_HI:`RAF_FVN_LO];
  assign slotted   = s_q.ctrl_b[`RAF_BIT_SLOTTED];
  assign auto_ack  = s_q.ctrl_b[`RAF_BIT_AUTO_ACK];
  assign rx_safe   = s_q.ctrl_b[`RAF_BIT_RX_SAFE];
  assign ftype     = mhr.fcf[2:0];
  assign dmode     = mhr.fcf[11:10];
  assign pan_ok    = (mhr.dst_pan == `RAF_BCAST) || (mhr.dst_pan == s_q.network_id);

  // second level: reserved frame types are dropped
  assign lvl2_ok = !ftype[2];

  always_comb
  begin
    addr_ok = 1'b0;
    case (dmode)
      2'b10: addr_ok = pan_ok && ((mhr.dst_addr[15:0] == `RAF_BCAST) ||
                                  (raf_is_short(s_q.short_addr) &&
                                   mhr.dst_addr[15:0] == s_q.short_addr));
      2'b11: addr_ok = pan_ok && (mhr.dst_addr == s_q.ieee);
      2'b00: addr_ok = (ftype == raf_pkg::RAF_FT_BEACON) ||
                       (coord && (ftype == raf_pkg::RAF_FT_DATA ||
                                  ftype == raf_pkg::RAF_FT_CMD));
      default: addr_ok = 1'b0;
    endcase
  end

  // ack only on good fcs, third-level pass, request bit and an allowed version
  assign ack_want = auto_ack && !ack_dis && rx_fcs_ok && lvl2_ok && addr_ok &&
                    mhr.fcf[5] && (ftype == raf_pkg::RAF_FT_DATA ||
                                   ftype == raf_pkg::RAF_FT_CMD) &&
                    raf_ver_ok(fvn_sel, mhr.fcf[13:12]);

  assign bus_req  = avs_read || avs_write;
  assign bus_take = bus_req && !s_q.wait_n;

  assign mhr.start      = phy_hdr_valid && s_q.st == raf_pkg::RAF_IDLE && !s_q.locked;
  assign mhr.byte_valid = rx_byte_valid && s_q.st == raf_pkg::RAF_RECV;
  assign mhr.byte_data  = rx_byte;

  always_comb
  begin
    s_d         = s_q;
    s_d.start_p = 1'b0;
    s_d.end_p   = 1'b0;
    s_d.ami_p   = 1'b0;
    s_d.ack_p   = 1'b0;
    // bus: first cycle latches the answer, second cycle completes it
    s_d.wait_n  = bus_req && !s_q.wait_n;
    if (bus_req && !s_q.wait_n)
    begin
      case (avs_address)
        `RAF_OFS_CTRL_A:    s_d.rdata = {24'h00_0000, s_q.ctrl_a};
        `RAF_OFS_CTRL_B:    s_d.rdata = {24'h00_0000, s_q.ctrl_b};
        `RAF_OFS_NODE_ADDR: s_d.rdata = {s_q.network_id, s_q.short_addr};
        `RAF_OFS_IEEE_LO:   s_d.rdata = s_q.ieee[31:0];
        `RAF_OFS_IEEE_HI:   s_d.rdata = s_q.ieee[63:32];
        `RAF_OFS_STATUS:    s_d.rdata = {29'h0000_0000, s_q.st != raf_pkg::RAF_IDLE,
                                         s_q.locked, s_q.crc_valid};
        default:            s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write && s_q.wait_n)
    begin
      // only the documented field positions act; other bits of the two control bytes are stored and ignored
      case (avs_address)
        `RAF_OFS_CTRL_A:    s_d.ctrl_a = avs_writedata[7:0];
        `RAF_OFS_CTRL_B:    s_d.ctrl_b = avs_writedata[7:0];
        `RAF_OFS_NODE_ADDR:
        begin
          s_d.short_addr = avs_writedata[15:0];
          s_d.network_id = avs_writedata[31:16];
        end
        `RAF_OFS_IEEE_LO:   s_d.ieee[31:0]  = avs_writedata;
        `RAF_OFS_IEEE_HI:   s_d.ieee[63:32] = avs_writedata;
        `RAF_OFS_STATUS:    if (avs_writedata[`RAF_ST_LOCKED]) s_d.locked = 1'b0;
        default: ;
      endcase
    end
    case (s_q.st)
      raf_pkg::RAF_IDLE:
      begin
        if (mhr.start)
        begin
          s_d.start_p = 1'b1;
          s_d.st      = raf_pkg::RAF_RECV;
        end
      end
      raf_pkg::RAF_RECV:
      begin
        if (rx_frame_done)
        begin
          s_d.crc_valid = rx_fcs_ok;
          s_d.ami_p     = lvl2_ok && addr_ok;
          s_d.end_p     = promisc ? lvl2_ok : (lvl2_ok && addr_ok && rx_fcs_ok);
          // a lock from this frame wins over a software unlock in the same cycle
          if (rx_safe && s_d.end_p) s_d.locked = 1'b1;
          s_d.ack_seq  = mhr.seq;
          s_d.ack_pend = pend_flag && ftype == raf_pkg::RAF_FT_CMD &&
                         mhr.cmd_id == `RAF_CMD_DATA_REQ;
          if (ack_want)
          begin
            s_d.ack_p = !slotted;
            s_d.st    = slotted ? raf_pkg::RAF_ACK_WAIT : raf_pkg::RAF_IDLE;
          end
          else
          begin
            s_d.st = raf_pkg::RAF_IDLE;
          end
        end
      end
      raf_pkg::RAF_ACK_WAIT:
      begin
        if (ack_slot_trigger)
        begin
          s_d.ack_p = 1'b1;
          s_d.st    = raf_pkg::RAF_IDLE;
        end
      end
      default: s_d.st = raf_pkg::RAF_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      s_q            <= '0;
      s_q.st         <= raf_pkg::RAF_IDLE;
      s_q.ctrl_a     <= `RAF_RST_CTRL;
      s_q.ctrl_b     <= `RAF_RST_CTRL;
      s_q.short_addr <= `RAF_RST_SHORT;
      s_q.network_id <= `RAF_RST_PAN;
      s_q.ieee       <= `RAF_RST_IEEE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata      = s_q.rdata;
  assign avs_waitrequest   = !s_q.wait_n;
  assign rx_start_irq      = s_q.start_p;
  assign rx_end_irq        = s_q.end_p;
  assign address_match_irq = s_q.ami_p;
  assign ack_tx_start      = s_q.ack_p;
  assign ack_seq           = s_q.ack_seq;
  assign ack_frame_pending = s_q.ack_pend;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_start_on_hdr: assert property (
    phy_hdr_valid && s_q.st == raf_pkg::RAF_IDLE && !s_q.locked |=> rx_start_irq)
    else $error("receive start missing after header");
  chk_prom_end_badfcs: assert property (
    s_q.st == raf_pkg::RAF_RECV && rx_frame_done && promisc && lvl2_ok |=> rx_end_irq)
    else $error("promiscuous receive end missing");
  chk_crc_with_end: assert property (
    rx_end_irq |-> s_q.crc_valid == $past(rx_fcs_ok))
    else $error("fcs status not updated with receive end");
  chk_ack_disabled: assert property (
    ack_dis && $past(ack_dis) && $past(ack_dis, 2) |-> !ack_tx_start)
    else $error("ack sent while disabled");
  chk_ack_version: assert property (
    s_q.st == raf_pkg::RAF_RECV && rx_frame_done && !raf_ver_ok(fvn_sel, mhr.fcf[13:12])
    |=> !ack_tx_start && s_q.st == raf_pkg::RAF_IDLE)
    else $error("ack for disallowed frame version");
  chk_ack_seq_copy: assert property (
    s_q.st == raf_pkg::RAF_RECV && rx_frame_done && ack_want && !slotted
    |=> ack_tx_start && ack_seq == $past(mhr.seq))
    else $error("ack sequence number wrong");
  chk_pend_only_dreq: assert property (
    s_q.st == raf_pkg::RAF_RECV && rx_frame_done &&
    (!pend_flag || ftype != raf_pkg::RAF_FT_CMD || mhr.cmd_id != `RAF_CMD_DATA_REQ)
    |=> !ack_frame_pending)
    else $error("pending set without flag or data request");
  chk_slot_wait: assert property (
    s_q.st == raf_pkg::RAF_ACK_WAIT && !ack_slot_trigger |=> !ack_tx_start)
    else $error("slotted ack sent without trigger");
  chk_lock_blocks: assert property (
    s_q.locked && phy_hdr_valid |=> !rx_start_irq)
    else $error("frame accepted into locked buffer");
  chk_bus_answer: assert property (
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  cov_acked: cover property (ack_tx_start);
  cov_prom_bad: cover property (rx_end_irq && !s_q.crc_valid);
  cov_slotted: cover property (s_q.st == raf_pkg::RAF_ACK_WAIT ##[1:20] ack_tx_start);

endmodule : raf_rx_filter
`default_nettype wire

// *** raf_radio_node.sv ***
// Purpose: remote radio node that sends frames into the receive filter
// Assumes: one byte per cycle, fcs result arrives with the done pulse
// Notes:   released data lines rx_byte and rx_fcs_ok show the inverse of their last value; strobes drop to 0
`timescale 1ns/100ps
`default_nettype none
module raf_radio_node
(
  input  wire logic       sys_clk,
  output logic            phy_hdr_valid,
  output logic            rx_byte_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_frame_done,
  output logic            rx_fcs_ok
);
  initial
  begin
    phy_hdr_valid = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte       = 8'h00;
    rx_frame_done = 1'b0;
    rx_fcs_ok     = 1'b0;
  end

  // ends three edges after done so every answer pulse has been counted
  task send(input logic [7:0] q[$], input logic fcs);
    begin
      phy_hdr_valid <= 1'b1;
      @(posedge sys_clk);
      phy_hdr_valid <= 1'b0;
      foreach (q[i])
      begin
        rx_byte_valid <= 1'b1;
        rx_byte       <= q[i];
        @(posedge sys_clk);
      end
      rx_byte_valid <= 1'b0;
      rx_byte       <= ~rx_byte;
      rx_frame_done <= 1'b1;
      rx_fcs_ok     <= fcs;
      @(posedge sys_clk);
      rx_frame_done <= 1'b0;
      rx_fcs_ok     <= ~fcs;
      repeat (3) @(posedge sys_clk);
    end
  endtask : send
endmodule : raf_radio_node
`default_nettype wire

// *** testbench.sv ***
// Purpose: self-checking bench of the receive filter and acknowledge decision
// Assumes: register answer one cycle after a request, pulses one cycle wide
// Notes:   answer pulses are counted per frame, not timed; design assertions time them
`timescale 1ns/100ps
`default_nettype none
`include "raf_consts.svh"
module testbench;
  logic        sys_clk;
  logic        srst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        phy_hdr_valid;
  logic        rx_byte_valid;
  logic [7:0]  rx_byte;
  logic        rx_frame_done;
  logic        rx_fcs_ok;
  logic        ack_slot_trigger;
  logic        rx_start_irq;
  logic        rx_end_irq;
  logic        address_match_irq;
  logic        ack_tx_start;
  logic [7:0]  ack_seq;
  logic        ack_frame_pending;
  logic [7:0]  last_seq;
  logic        last_pend;
  logic [31:0] rdata;
  int          failures;
  int          samples_checked;
  int          n_start;
  int          n_end;
  int          n_match;
  int          n_ack;

  raf_rx_filter i_raf_rx_filter
  (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .phy_hdr_valid(phy_hdr_valid),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_frame_done(rx_frame_done),
    .rx_fcs_ok(rx_fcs_ok), .ack_slot_trigger(ack_slot_trigger),
    .rx_start_irq(rx_start_irq), .rx_end_irq(rx_end_irq),
    .address_match_irq(address_match_irq), .ack_tx_start(ack_tx_start),
    .ack_seq(ack_seq), .ack_frame_pending(ack_frame_pending)
  );

  raf_radio_node i_raf_radio_node
  (
    .sys_clk(sys_clk), .phy_hdr_valid(phy_hdr_valid), .rx_byte_valid(rx_byte_valid),
    .rx_byte(rx_byte), .rx_frame_done(rx_frame_done), .rx_fcs_ok(rx_fcs_ok)
  );

  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (rx_start_irq === 1'b1)
      n_start <= n_start + 1;
    if (rx_end_irq === 1'b1)
      n_end <= n_end + 1;
    if (address_match_irq === 1'b1)
      n_match <= n_match + 1;
    if (ack_tx_start === 1'b1)
    begin
      n_ack     <= n_ack + 1;
      last_seq  <= ack_seq;
      last_pend <= ack_frame_pending;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : chk

  task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int n;
    begin
      avs_address   <= a;
      avs_writedata <= wd;
      avs_read      <= ~wr;
      avs_write     <= wr;
      n = 0;
      do
      begin
        @(posedge sys_clk);
        n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
        failures++;
      rdata = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : bus

  task rdchk(input logic [5:0] a, input logic [31:0] exp);
    begin
      bus(1'b0, a, 32'h0000_0000);
      chk(rdata, exp);
    end
  endtask : rdchk

  // exp holds the expected pulses as start, end, match, ack
  task rx(input logic [15:0] fcf, input logic [7:0] seq, input logic [15:0] pan,
          input logic [15:0] dst, input logic [7:0] cmd, input logic fcs,
          input logic [3:0] exp, input logic epend);
    int         s;
    int         e;
    int         m;
    int         k;
    logic [7:0] q[$];
    begin
      s = n_start;
      e = n_end;
      m = n_match;
      k = n_ack;
      q = '{fcf[7:0], fcf[15:8], seq, pan[7:0], pan[15:8], dst[7:0], dst[15:8], cmd};
      i_raf_radio_node.send(q, fcs);
      chk(32'({n_start - s == 1, n_end - e == 1, n_match - m == 1, n_ack - k == 1}),
          32'(exp));
      if (exp[0])
        chk(32'({last_pend, last_seq}), 32'({epend, seq}));
    end
  endtask : rx

  task t_reset;
    begin
      rdchk(`RAF_OFS_CTRL_A, 32'h0000_0000);
      rdchk(`RAF_OFS_CTRL_B, 32'h0000_0000);
      rdchk(`RAF_OFS_NODE_ADDR, 32'hffff_ffff);
      rdchk(`RAF_OFS_IEEE_HI, 32'h0000_0000);
      rdchk(`RAF_OFS_STATUS, 32'h0000_0000);
      bus(1'b1, 6'h18, 32'h1234_5678);
      rdchk(6'h18, 32'h0000_0000);
    end
  endtask : t_reset

  task t_unconf;
    int         e;
    int         m;
    int         k;
    logic [7:0] q[$];
    begin
      // basic receive: auto-ack off, so a request bit gets no ack
      rx(16'h0821, 8'h10, 16'hffff, 16'hffff, 8'h00, 1'b1, 4'b1110, 1'b0);
      bus(1'b1, `RAF_OFS_CTRL_B, 32'h0000_0002);
      rx(16'h0801, 8'h11, 16'hffff, 16'hffff, 8'h00, 1'b1, 4'b1110, 1'b0);
      rx(16'h0801, 8'h12, 16'hffff, 16'h1234, 8'h00, 1'b1, 4'b1000, 1'b0);
      bus(1'b1, `RAF_OFS_NODE_ADDR, 32'hffff_fffe);
      rx(16'h0801, 8'h13, 16'hffff, 16'hfffe, 8'h00, 1'b1, 4'b1000, 1'b0);
      // extended destination still reaches the node without a short address
      bus(1'b1, `RAF_OFS_IEEE_LO, 32'h8765_4321);
      bus(1'b1, `RAF_OFS_IEEE_HI, 32'h0fed_cba9);
      e = n_end;
      m = n_match;
      k = n_ack;
      q = '{8'h21, 8'h0c, 8'h14, 8'hff, 8'hff, 8'h21, 8'h43, 8'h65, 8'h87,
            8'ha9, 8'hcb, 8'hed, 8'h0f};
      i_raf_radio_node.send(q, 1'b1);
      chk(32'({n_end - e == 1, n_match - m == 1, n_ack - k == 1, last_seq}),
          32'h0000_0714);
    end
  endtask : t_unconf

  task t_version;
    begin
      bus(1'b1, `RAF_OFS_NODE_ADDR, 32'habcd_1234);
      for (int f = 0; f < 4; f++)
      begin
        bus(1'b1, `RAF_OFS_CTRL_A, 32'(f << 6));
        for (int v = 0; v < 4; v++)
          rx(16'(16'h0821 | (v << 12)), 8'(f * 16 + v), 16'habcd, 16'h1234, 8'h00,
             1'b1, {3'b111, v <= f}, 1'b0);
      end
      bus(1'b1, `RAF_OFS_CTRL_A, 32'h0000_0010);
      rx(16'h0821, 8'h40, 16'habcd, 16'h1234, 8'h00, 1'b1, 4'b1110, 1'b0);
    end
  endtask : t_version

  task t_coord;
    begin
      bus(1'b1, `RAF_OFS_CTRL_A, 32'h0000_0028);
      rx(16'h0823, 8'h50, 16'habcd, 16'h1234, 8'h04, 1'b1, 4'b1111, 1'b1);
      rx(16'h0823, 8'h51, 16'habcd, 16'h1234, 8'h05, 1'b1, 4'b1111, 1'b0);
      rx(16'h0821, 8'h52, 16'habcd, 16'h1234, 8'h04, 1'b1, 4'b1111, 1'b0);
      rx(16'h0001, 8'h53, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1110, 1'b0);
      bus(1'b1, `RAF_OFS_CTRL_A, 32'h0000_0000);
      rx(16'h0823, 8'h54, 16'habcd, 16'h1234, 8'h04, 1'b1, 4'b1111, 1'b0);
      rx(16'h0001, 8'h55, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1000, 1'b0);
    end
  endtask : t_coord

  task t_prom;
    begin
      bus(1'b1, `RAF_OFS_NODE_ADDR, 32'h0000_0000);
      bus(1'b1, `RAF_OFS_IEEE_LO, 32'h0000_0000);
      bus(1'b1, `RAF_OFS_IEEE_HI, 32'h0000_0000);
      bus(1'b1, `RAF_OFS_CTRL_A, 32'h0000_0002);
      rx(16'h0821, 8'h60, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1111, 1'b0);
      rdchk(`RAF_OFS_STATUS, 32'h0000_0001);
      rx(16'h0821, 8'h61, 16'h0000, 16'h5555, 8'h00, 1'b0, 4'b1100, 1'b0);
      rdchk(`RAF_OFS_STATUS, 32'h0000_0000);
      rx(16'h0821, 8'h62, 16'h0000, 16'h5555, 8'h00, 1'b1, 4'b1100, 1'b0);
      rx(16'h0805, 8'h63, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1000, 1'b0);
      bus(1'b1, `RAF_OFS_CTRL_A, 32'h0000_0012);
      rx(16'h0821, 8'h64, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1110, 1'b0);
      bus(1'b1, `RAF_OFS_CTRL_A, 32'h0000_0000);
    end
  endtask : t_prom

  task t_slot;
    int k;
    begin
      bus(1'b1, `RAF_OFS_CTRL_B, 32'h0000_0003);
      rx(16'h0821, 8'h77, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1110, 1'b0);
      k = n_ack;
      ack_slot_trigger <= 1'b1;
      @(posedge sys_clk);
      ack_slot_trigger <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk(32'({n_ack - k == 1, last_seq}), 32'h0000_0177);
    end
  endtask : t_slot

  task t_safe;
    begin
      bus(1'b1, `RAF_OFS_CTRL_B, 32'h0000_0082);
      rx(16'h0821, 8'h80, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1111, 1'b0);
      rdchk(`RAF_OFS_STATUS, 32'h0000_0003);
      rx(16'h0821, 8'h81, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b0000, 1'b0);
      bus(1'b1, `RAF_OFS_CTRL_B, 32'h0000_0002);
      bus(1'b1, `RAF_OFS_STATUS, 32'h0000_0002);
      rdchk(`RAF_OFS_STATUS, 32'h0000_0001);
      rx(16'h0821, 8'h82, 16'h0000, 16'h0000, 8'h00, 1'b1, 4'b1111, 1'b0);
    end
  endtask : t_safe

  task end_sim;
    begin
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask : end_sim

  // about 600 cycles are expected; the margin covers a stuck handshake
  initial
  begin
    repeat (8000) @(posedge sys_clk);
    failures++;
    end_sim;
  end

  initial
  begin
    sys_clk          = 1'b0;
    srst             = 1'b1;
    avs_address      = 6'h00;
    avs_read         = 1'b0;
    avs_write        = 1'b0;
    avs_writedata    = 32'h0000_0000;
    ack_slot_trigger = 1'b0;
    failures         = 0;
    samples_checked  = 0;
    n_start          = 0;
    n_end            = 0;
    n_match          = 0;
    n_ack            = 0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_unconf;
    t_version;
    t_coord;
    t_prom;
    t_slot;
    t_safe;
    end_sim;
  end
endmodule : testbench
`default_nettype wire
